// file: core/rfsb_defines.vh
// register offsets, field positions, reset values and timing counts for the fault status bank
`ifndef RFSB_DEFINES_VH
`define RFSB_DEFINES_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define RFSB_ADDR_LINREG_EVENT 8'h1C
`define RFSB_ADDR_TOP_STATUS 8'h1D
`define RFSB_ADDR_SWITCHER_STATUS 8'h1E

// ****************************************************************
// linear regulator event register fields
// ****************************************************************
`define RFSB_EV_A_OVERCURRENT 0
`define RFSB_EV_A_SHORT 1
`define RFSB_EV_A_GOOD 2
`define RFSB_EV_B_OVERCURRENT 4
`define RFSB_EV_B_SHORT 5
`define RFSB_EV_B_GOOD 6
`define RFSB_EV_IMPL_MASK 8'h77
`define RFSB_EV_RESET 8'h00

// ****************************************************************
// top status register fields
// ****************************************************************
`define RFSB_TOP_OVERVOLTAGE 1
`define RFSB_TOP_THERMAL_WARN 2
`define RFSB_TOP_THERMAL_SHUT 3
`define RFSB_TOP_SYNC_INVALID 4
`define RFSB_TOP_POWER_GOOD 7
`define RFSB_TOP_RESET 8'h00

// ****************************************************************
// switcher status register fields
// ****************************************************************
`define RFSB_SW_A_LIMIT 0
`define RFSB_SW_A_INVALID 2
`define RFSB_SW_A_ENABLED 3
`define RFSB_SW_B_LIMIT 4
`define RFSB_SW_B_INVALID 6
`define RFSB_SW_B_ENABLED 7
`define RFSB_SW_RESET 8'h00

// ****************************************************************
// timing
// ****************************************************************
`define RFSB_CLK_MHZ 250
`define RFSB_SHORT_TIME_US 1000
// more than 1 ms at 250 MHz: 250000 cycles plus one, sized to the counter
`define RFSB_SHORT_CYCLES 18'h3D091
`define RFSB_SHORT_CNT_W 18

`endif

// file: core/rfsb_short_filter.v
// short-circuit qualifier: asserts after the low condition persists past the limit
`timescale 1ns/10ps
module rfsb_short_filter #(
  parameter [17:0] LIMIT = 18'h3D091
) (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // condition, already synchronised
  input wire below_threshold,
  // one-cycle pulse when the condition has lasted past the limit
  output reg qualified_pulse
);

  reg [17:0] count_q;

  // ****************************************************************
  // continuous-duration counter
  // ****************************************************************
  // any gap restarts the count, so only an unbroken low interval qualifies
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= 18'h00000;
      qualified_pulse <= 1'b0;
    end else begin
      qualified_pulse <= 1'b0;
      if (!below_threshold) begin
        count_q <= 18'h00000;
      end else if (count_q < LIMIT) begin
        count_q <= count_q + 18'h00001;
        if (count_q == LIMIT - 18'h00001) begin
          qualified_pulse <= 1'b1;
        end
      end
    end
  end

endmodule // rfsb_short_filter

// file: core/rfsb_status_bank.v
// regulator fault status bank: latched linear-regulator events and live status registers
// Summary of operation
// R1: linreg b good event latched at bit 6
// R2: linreg a good event latched at bit 2
// R3: linreg b short latched after over 1 ms
// R4: linreg a short latched after over 1 ms
// R5: linreg b current limit latched at bit 4
// R6: linreg a current limit latched at bit 0
// R7: event flags clear by writing one; reset zero
// R8: power good pin level at top bit 7
// R9: sync clock invalid reads one at bit 4
// R10: thermal shutdown now at top bit 3
// R11: thermal warning now at top bit 2
// R12: input overvoltage now at top bit 1
// R13: switcher b enabled at bit 7
// R14: switcher a enabled at bit 3
// R15: switcher b output invalid at bit 6
// R16: switcher a output invalid at bit 2
// R17: switcher b limit now at bit 4
// R18: switcher a limit now at bit 0
// R19: switcher status live, read-only, resets zero
// R20: summary flag drops when events all clear
// R21: reserved bits read zero, writes ignored
// R22: recurring event beats simultaneous clear
`timescale 1ns/10ps
`include "rfsb_defines.vh"
module rfsb_status_bank (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // register port from the serial link engine, same clock domain
  input wire [7:0] reg_addr,
  input wire reg_wr_en,
  input wire [7:0] reg_wr_data,
  input wire reg_rd_en,
  output reg [7:0] reg_rd_data,
  output reg reg_rd_valid,
  // linear regulator detectors, asynchronous
  input wire linreg_a_good_evt_in,
  input wire linreg_a_below_short_in,
  input wire linreg_a_limit_in,
  input wire linreg_b_good_evt_in,
  input wire linreg_b_below_short_in,
  input wire linreg_b_limit_in,
  // top level detectors, asynchronous
  input wire power_good_output,
  input wire sync_clock_invalid_in,
  input wire thermal_shutdown_in,
  input wire thermal_warning_in,
  input wire input_overvoltage_in,
  // switcher detectors, asynchronous
  input wire switcher_a_enabled_in,
  input wire switcher_a_invalid_in,
  input wire switcher_a_limit_in,
  input wire switcher_b_enabled_in,
  input wire switcher_b_invalid_in,
  input wire switcher_b_limit_in,
  // summary to the top interrupt register
  output reg linreg_summary_flag
);

  localparam [17:0] SHORT_LIMIT = `RFSB_SHORT_CYCLES;
  localparam NSYNC = 17;

  // sync vector bit order
  localparam S_A_GOOD = 0;
  localparam S_A_SHORT = 1;
  localparam S_A_LIM = 2;
  localparam S_B_GOOD = 3;
  localparam S_B_SHORT = 4;
  localparam S_B_LIM = 5;
  localparam S_PG = 6;
  localparam S_SYNC = 7;
  localparam S_TSD = 8;
  localparam S_TWARN = 9;
  localparam S_OVP = 10;
  localparam S_SWA_EN = 11;
  localparam S_SWA_INV = 12;
  localparam S_SWA_LIM = 13;
  localparam S_SWB_EN = 14;
  localparam S_SWB_INV = 15;
  localparam S_SWB_LIM = 16;

  wire [NSYNC-1:0] raw_in;
  reg [NSYNC-1:0] meta_q;
  reg [NSYNC-1:0] sync_q;
  reg linreg_a_good_prev_q;
  reg linreg_b_good_prev_q;
  reg [7:0] events_q;
  reg [7:0] events_d;
  reg [7:0] top_q;
  reg [7:0] switcher_q;
  reg [7:0] set_vec;
  reg [7:0] clr_vec;
  reg [7:0] rd_mux;
  reg wr_event_hit;
  wire short_a_pulse;
  wire short_b_pulse;

  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // one-hot read select: bit 0 events, bit 1 top, bit 2 switcher
  function [2:0] rd_select;
    input [7:0] addr;
    begin
      rd_select = 3'b000;
      rd_select[0] = addr_hit(addr, `RFSB_ADDR_LINREG_EVENT);
      rd_select[1] = addr_hit(addr, `RFSB_ADDR_TOP_STATUS);
      rd_select[2] = addr_hit(addr, `RFSB_ADDR_SWITCHER_STATUS);
    end
  endfunction

  assign raw_in = {
    // switcher detectors
    switcher_b_limit_in,
    switcher_b_invalid_in,
    switcher_b_enabled_in,
    switcher_a_limit_in,
    switcher_a_invalid_in,
    switcher_a_enabled_in,
    // top level detectors
    input_overvoltage_in,
    thermal_warning_in,
    thermal_shutdown_in,
    sync_clock_invalid_in,
    power_good_output,
    // linear regulator detectors
    linreg_b_limit_in,
    linreg_b_below_short_in,
    linreg_b_good_evt_in,
    linreg_a_limit_in,
    linreg_a_below_short_in,
    linreg_a_good_evt_in
  };

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= raw_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // short-circuit qualification
  // ****************************************************************
  rfsb_short_filter #(
    .LIMIT(SHORT_LIMIT)
  ) u_short_a (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .below_threshold(sync_q[S_A_SHORT]),
    .qualified_pulse(short_a_pulse)
  ); // R4

  rfsb_short_filter #(
    .LIMIT(SHORT_LIMIT)
  ) u_short_b (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .below_threshold(sync_q[S_B_SHORT]),
    .qualified_pulse(short_b_pulse)
  ); // R3

  // ****************************************************************
  // write decode
  // ****************************************************************
  // only the event register takes writes; other offsets are dropped here
  always @* begin
    wr_event_hit = 1'b0;
    if (reg_wr_en) begin
      wr_event_hit = addr_hit(reg_addr, `RFSB_ADDR_LINREG_EVENT);
    end
  end

  // ****************************************************************
  // event latching
  // ****************************************************************
  // power-good event taken as a rising edge of the detector indication
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      linreg_a_good_prev_q <= 1'b0;
      linreg_b_good_prev_q <= 1'b0;
    end else begin
      linreg_a_good_prev_q <= sync_q[S_A_GOOD];
      linreg_b_good_prev_q <= sync_q[S_B_GOOD];
    end
  end

  always @* begin
    set_vec = 8'h00;
    set_vec[`RFSB_EV_B_GOOD] = sync_q[S_B_GOOD] & ~linreg_b_good_prev_q; // R1
    set_vec[`RFSB_EV_A_GOOD] = sync_q[S_A_GOOD] & ~linreg_a_good_prev_q; // R2
    set_vec[`RFSB_EV_B_SHORT] = short_b_pulse; // R3
    set_vec[`RFSB_EV_A_SHORT] = short_a_pulse; // R4
    // level set: a limit held across a clear re-latches at once
    set_vec[`RFSB_EV_B_OVERCURRENT] = sync_q[S_B_LIM]; // R5
    set_vec[`RFSB_EV_A_OVERCURRENT] = sync_q[S_A_LIM]; // R6
    clr_vec = 8'h00;
    if (wr_event_hit) begin
      clr_vec = reg_wr_data & `RFSB_EV_IMPL_MASK; // R7 R21
    end
    // set after clear so a coincident event survives
    events_d = ((events_q & ~clr_vec) | set_vec) & `RFSB_EV_IMPL_MASK; // R22
  end

  // ****************************************************************
  // event flag storage
  // ****************************************************************
  // reserved positions get a flop tied to zero so reads need no masking
  genvar ei;
  generate
    for (ei = 0; ei < 8; ei = ei + 1) begin : g_event
      if (((`RFSB_EV_IMPL_MASK >> ei) & 8'h01) != 8'h00) begin : g_impl
        always @(posedge core_clk or posedge sys_rst) begin
          if (sys_rst) begin
            events_q[ei] <= 1'b0; // R7
          end else begin
            events_q[ei] <= events_d[ei];
          end
        end
      end else begin : g_rsvd
        always @(posedge core_clk or posedge sys_rst) begin
          if (sys_rst) begin
            events_q[ei] <= 1'b0;
          end else begin
            events_q[ei] <= 1'b0; // R21
          end
        end
      end
    end
  endgenerate

  // follows the next state so it drops in the cycle the last flag clears
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      linreg_summary_flag <= 1'b0;
    end else begin
      linreg_summary_flag <= |events_d; // R20
    end
  end

  // ****************************************************************
  // live status capture
  // ****************************************************************
  // registered copies of the synced levels; host writes never reach them
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      top_q <= `RFSB_TOP_RESET;
    end else begin
      top_q <= 8'h00; // R21
      top_q[`RFSB_TOP_POWER_GOOD] <= sync_q[S_PG]; // R8
      top_q[`RFSB_TOP_SYNC_INVALID] <= sync_q[S_SYNC]; // R9
      top_q[`RFSB_TOP_THERMAL_SHUT] <= sync_q[S_TSD]; // R10
      top_q[`RFSB_TOP_THERMAL_WARN] <= sync_q[S_TWARN]; // R11
      top_q[`RFSB_TOP_OVERVOLTAGE] <= sync_q[S_OVP]; // R12
    end
  end

  // raw levels, no latching: a brief limit may be missed between reads
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      switcher_q <= `RFSB_SW_RESET; // R19
    end else begin
      switcher_q <= 8'h00; // R21
      switcher_q[`RFSB_SW_B_ENABLED] <= sync_q[S_SWB_EN]; // R13
      switcher_q[`RFSB_SW_A_ENABLED] <= sync_q[S_SWA_EN]; // R14
      switcher_q[`RFSB_SW_B_INVALID] <= sync_q[S_SWB_INV]; // R15
      switcher_q[`RFSB_SW_A_INVALID] <= sync_q[S_SWA_INV]; // R16
      switcher_q[`RFSB_SW_B_LIMIT] <= sync_q[S_SWB_LIM]; // R17
      switcher_q[`RFSB_SW_A_LIMIT] <= sync_q[S_SWA_LIM]; // R18
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  // unmapped offsets read zero; the link engine owns the rest of the map
  always @* begin
    rd_mux = 8'h00;
    case (rd_select(reg_addr))
      3'b001: begin
        rd_mux = events_q;
      end
      3'b010: begin
        rd_mux = top_q;
      end
      3'b100: begin
        rd_mux = switcher_q; // R19
      end
      default: begin
        rd_mux = 8'h00; // R21
      end
    endcase
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rd_data <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rd_data <= rd_mux;
      end
    end
  end

endmodule // rfsb_status_bank

// file: verif/rfsb_properties.sv
// checker for the fault status bank register port and summary flag
`timescale 1ns/10ps
module rfsb_checker (
  // clock and reset
  input wire core_clk,
  input wire sys_rst,
  // register port
  input wire [7:0] reg_addr,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [7:0] reg_rd_data,
  input wire reg_rd_valid,
  // detectors and summary
  input wire linreg_a_limit_in,
  input wire linreg_b_limit_in,
  input wire linreg_summary_flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_rd_valid_timing: assert property (reg_rd_valid == $past(reg_rd_en))
    else $error("read valid timing wrong");
  a_event_reserved_zero: assert property (
    reg_rd_valid && $past(reg_addr) == 8'h1C |-> (reg_rd_data & 8'h88) == 8'h00)
    else $error("event reserved bit set");
  a_top_reserved_zero: assert property (
    reg_rd_valid && $past(reg_addr) == 8'h1D |-> (reg_rd_data & 8'h61) == 8'h00)
    else $error("top reserved bit set");
  a_sw_reserved_zero: assert property (
    reg_rd_valid && $past(reg_addr) == 8'h1E |-> (reg_rd_data & 8'h22) == 8'h00)
    else $error("switcher reserved bit set");
  a_unmapped_reads_zero: assert property (
    reg_rd_valid && ($past(reg_addr) < 8'h1C || $past(reg_addr) > 8'h1E)
    |-> reg_rd_data == 8'h00) else $error("unmapped read not zero");
  a_rd_data_holds: assert property (!reg_rd_valid |-> $stable(reg_rd_data))
    else $error("read data moved");
  a_limit_a_latch: assert property (linreg_a_limit_in [*6] |-> linreg_summary_flag)
    else $error("limit a not latched");
  a_limit_b_latch: assert property (linreg_b_limit_in [*6] |-> linreg_summary_flag)
    else $error("limit b not latched");
  a_summary_fall_cause: assert property ($fell(linreg_summary_flag)
    |-> $past(reg_wr_en) && $past(reg_addr) == 8'h1C) else $error("summary fell alone");
  c_event_read: cover property (reg_rd_valid && $past(reg_addr) == 8'h1C && reg_rd_data != 0);
  c_summary_fall: cover property ($fell(linreg_summary_flag));
  c_unmapped: cover property (reg_rd_valid && $past(reg_addr) == 8'h55);
endmodule // rfsb_checker

// file: verif/rfsb_host_model.sv
// host model: single-byte reads and writes over the strobe port
`timescale 1ns/10ps
module rfsb_host_model (
  // clock
  input wire core_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_en,
  input wire [7:0] reg_rd_data,
  input wire reg_rd_valid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
  end
  // a one in the data clears that flag
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(posedge core_clk) #1;
    reg_wr_en = 1'b0;
    // released data must not look like the last byte
    reg_wr_data = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge core_clk) #1;
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge core_clk) #1;
    reg_rd_en = 1'b0;
    ok = reg_rd_valid;
    d = reg_rd_data;
  endtask
endmodule // rfsb_host_model

// file: verif/regulator_fault_status_bank_tb.sv
// self-checking bench for the regulator fault status bank
`timescale 1ns/10ps
module regulator_fault_status_bank_tb;
  logic core_clk = 1'b0;
  logic sys_rst;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
  logic reg_wr_en, reg_rd_en, reg_rd_valid, sum_flag;
  logic [10:0] live;
  logic [5:0] ev;
  logic [31:0] seed = 32'h00000043;
  int err_total = 0;
  int n_compared = 0;
  logic [5:0] stim [4] = '{6'h01, 6'h04, 6'h08, 6'h20};
  logic [7:0] flag_bit [4] = '{8'h04, 8'h01, 8'h40, 8'h10};
  always #2 core_clk = ~core_clk;
  rfsb_host_model i_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid));
  rfsb_status_bank i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .linreg_a_good_evt_in(ev[0]), .linreg_a_below_short_in(ev[1]),
    .linreg_a_limit_in(ev[2]), .linreg_b_good_evt_in(ev[3]),
    .linreg_b_below_short_in(ev[4]), .linreg_b_limit_in(ev[5]),
    .power_good_output(live[0]), .sync_clock_invalid_in(live[1]),
    .thermal_shutdown_in(live[2]), .thermal_warning_in(live[3]),
    .input_overvoltage_in(live[4]), .switcher_a_enabled_in(live[5]),
    .switcher_a_invalid_in(live[6]), .switcher_a_limit_in(live[7]),
    .switcher_b_enabled_in(live[8]), .switcher_b_invalid_in(live[9]),
    .switcher_b_limit_in(live[10]), .linreg_summary_flag(sum_flag));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction
  function automatic logic [7:0] exp_top(input logic [10:0] v);
    exp_top = {v[0], 2'b00, v[1], v[2], v[3], v[4], 1'b0};
  endfunction
  function automatic logic [7:0] exp_sw(input logic [10:0] v);
    exp_sw = {v[8], v[9], 1'b0, v[10], v[5], v[6], 1'b0, v[7]};
  endfunction
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    i_host.rd(a, d, ok);
    cmp({ok, d}, {1'b1, e});
  endtask
  task automatic close_out();
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    live = 11'h000;
    ev = 6'h00;
    sys_rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    chk(8'h1C, 8'h00);
    chk(8'h1D, 8'h00);
    chk(8'h1E, 8'h00);
    chk(8'h55, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk) #1 ev = stim[i];
      repeat (3) @(posedge core_clk);
      #1 ev = 6'h00;
      repeat (6) @(posedge core_clk);
      chk(8'h1C, flag_bit[i]);
      cmp({8'h00, sum_flag}, 9'h001);
      i_host.wr(8'h1C, ~flag_bit[i]);
      chk(8'h1C, flag_bit[i]);
      i_host.wr(8'h1C, 8'hFF);
      chk(8'h1C, 8'h00);
      cmp({8'h00, sum_flag}, 9'h000);
    end
    // limit held on through the clearing write
    ev = 6'h04;
    repeat (8) @(posedge core_clk);
    i_host.wr(8'h1C, 8'h01);
    chk(8'h1C, 8'h01);
    ev = 6'h00;
    // let the synchroniser drain first, or the held level re-latches
    repeat (4) @(posedge core_clk);
    i_host.wr(8'h1C, 8'h01);
    chk(8'h1C, 8'h00);
    // short dips far below the qualifying time must not latch
    ev = 6'h12;
    repeat (40) @(posedge core_clk);
    #1 ev = 6'h00;
    repeat (6) @(posedge core_clk);
    chk(8'h1C, 8'h00);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      live = seed[10:0];
      i_host.wr(seed[12] ? 8'h1D : 8'h1E, seed[31:24]);
      repeat (5) @(posedge core_clk);
      chk(8'h1D, exp_top(live));
      chk(8'h1E, exp_sw(live));
    end
    close_out();
  end
  // whole run is under a thousand cycles; allow five times that
  initial begin
    #20000;
    err_total++;
    close_out();
  end
endmodule // regulator_fault_status_bank_tb
bind rfsb_status_bank rfsb_checker i_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
  .linreg_a_limit_in(linreg_a_limit_in), .linreg_b_limit_in(linreg_b_limit_in),
  .linreg_summary_flag(linreg_summary_flag));
